// ===== shared/supervisor_pkg.sv
/*
  Constants, types and helper functions for the supervisor and window watchdog.
  Assumes a single system clock; all intervals are counted in 1 us ticks.
*/
package supervisor_pkg;

  // Time base
  localparam int CLK_MHZ    = 250;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int DLY_W      = 22;

  typedef logic [DLY_W-1:0] dly_t;

  // Intervals in microseconds
  localparam dly_t PROBE_US       = 22'h00017D;
  localparam dly_t SETTLE_US      = 22'h000096;
  localparam dly_t RST_NC_US      = 22'h030D40;
  localparam dly_t RST_RES_US     = 22'h002710;
  localparam dly_t RST_CAP_MIN_US = 22'h0002BF;
  localparam dly_t RST_CAP_MAX_US = 22'h312220;
  localparam dly_t WDU_NC_18      = 22'h00D6D8;
  localparam dly_t WDU_NC_34      = 22'h006B6C;
  localparam dly_t WDU_NC_12      = 22'h186A00;
  localparam dly_t WDU_RES_18     = 22'h01A9C8;
  localparam dly_t WDU_RES_34     = 22'h02F9B8;
  localparam dly_t WDU_RES_12     = 22'h002AF8;

  // Register map
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_RST_CAP = 8'h04;
  localparam logic [7:0] REG_WD_CAP  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic       CTRL_RST    = 1'b0;
  localparam dly_t       RST_CAP_RST = RST_CAP_MIN_US;
  localparam dly_t       WD_CAP_RST  = 22'h002710;
  localparam int         CTRL_ADJ_BIT = 0;

  // Status fields
  localparam int ST_RESET_BIT = 0;
  localparam int ST_WDO_BIT   = 1;
  localparam int ST_EN_BIT    = 2;
  localparam int ST_FIRST_BIT = 3;
  localparam int ST_MODE_LSB  = 4;
  localparam int ST_RCFG_LSB  = 6;
  localparam int ST_WCFG_LSB  = 8;

  typedef enum logic [1:0] {
    PIN_OPEN   = 2'b00,
    PIN_PULLUP = 2'b01,
    PIN_CAP    = 2'b10
  } pin_cfg_t;

  // Mode code is {select0, select1}
  typedef enum logic [1:0] {
    WD_R1_8 = 2'b00,
    WD_R3_4 = 2'b01,
    WD_OFF  = 2'b10,
    WD_R1_2 = 2'b11
  } wd_mode_t;

  typedef enum logic [1:0] {
    RS_HOLD  = 2'b00,
    RS_PROBE = 2'b01,
    RS_DELAY = 2'b10,
    RS_RUN   = 2'b11
  } rst_state_t;

  function automatic dly_t clamp_cap(input dly_t v);
    if (v < RST_CAP_MIN_US) return RST_CAP_MIN_US;
    if (v > RST_CAP_MAX_US) return RST_CAP_MAX_US;
    return v;
  endfunction : clamp_cap

  function automatic dly_t rst_len_of(input logic [1:0] c, input dly_t cap);
    if (c == PIN_OPEN) return RST_NC_US;
    if (c == PIN_PULLUP) return RST_RES_US;
    return clamp_cap(cap);
  endfunction : rst_len_of

  function automatic dly_t upper_of(input logic [1:0] c, input wd_mode_t m, input dly_t cap);
    if (c == PIN_OPEN)
      return (m == WD_R1_8) ? WDU_NC_18 : (m == WD_R3_4) ? WDU_NC_34 : WDU_NC_12;
    if (c == PIN_PULLUP)
      return (m == WD_R1_8) ? WDU_RES_18 : (m == WD_R3_4) ? WDU_RES_34 : WDU_RES_12;
    return cap;
  endfunction : upper_of

  function automatic dly_t lower_of(input dly_t u, input wd_mode_t m);
    if (m == WD_R1_8) return u >> 3;
    if (m == WD_R3_4) return (u >> 1) + (u >> 2);
    return u >> 1;
  endfunction : lower_of

endpackage : supervisor_pkg

// ===== shared/timer_if.sv
/*
  Control and status of one interval timer.
  Assumes the controller and the timer share the system clock.
*/
interface timer_if;
  logic                 start;
  logic                 stop;
  supervisor_pkg::dly_t length;
  logic                 busy;
  logic                 done;
  modport ctl (output start, output stop, output length, input busy, input done);
  modport tmr (input start, input stop, input length, output busy, output done);
endinterface : timer_if

// ===== rtl/pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to the clock.
*/
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync

// ===== rtl/interval_timer.sv
/*
  Down counter on the 1 us tick; done pulses one cycle after the last tick.
  Assumes start has priority over stop and a zero length acts as one tick.
*/
module interval_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Time base
  input  wire logic tick,
  // Control
  timer_if.tmr      t
);

  supervisor_pkg::dly_t cnt_q;
  logic                 busy_q;
  logic                 done_q;

  assign t.busy = busy_q;
  assign t.done = done_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (t.start) begin
      cnt_q  <= (t.length == '0) ? supervisor_pkg::dly_t'(1) : t.length;
      busy_q <= 1'b1;
    end else if (t.stop) begin
      busy_q <= 1'b0;
    end else if (tick && busy_q) begin
      cnt_q <= cnt_q - supervisor_pkg::dly_t'(1);
      if (cnt_q == supervisor_pkg::dly_t'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && tick && !t.start && !t.stop && (cnt_q == supervisor_pkg::dly_t'(1));
    end
  end

endmodule : interval_timer

// ===== rtl/supervisor_window_watchdog.sv
/*
  Voltage supervisor reset sequencer with window watchdog and APB registers.
  Assumes comparator results and probe codes arrive as asynchronous pins and
  open-drain wires are resolved outside from output and enable.
*/
module supervisor_window_watchdog #(
  parameter int CYC_PER_US = supervisor_pkg::CYC_PER_US
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Comparator results
  input  wire logic        SENSE_UNDER,
  input  wire logic        SENSE_OVER,
  input  wire logic        SUPPLY_LOCKOUT,
  // Configuration pin probing
  input  wire logic [1:0]  RESET_DELAY_CONFIG_PIN,
  input  wire logic [1:0]  WATCHDOG_TIMING_CONFIG_PIN,
  output logic             PROBE_ACTIVE,
  // Watchdog pins
  input  wire logic        WINDOW_SELECT0,
  input  wire logic        WINDOW_SELECT1,
  input  wire logic        WATCHDOG_KICK_IN,
  // Open-drain outputs
  output logic             RESET_N_O,
  output logic             RESET_N_OE,
  output logic             WATCHDOG_FAULT_OUT_N_O,
  output logic             WATCHDOG_FAULT_OUT_N_OE
);

  localparam logic [7:0] PRE_MAX = 8'(CYC_PER_US - 1);

  logic [7:0]                  pre_q;
  logic                        tick;
  logic [9:0]                  sync_q;
  logic                        s_under, s_over, s_lock, s_kick;
  logic [1:0]                  s_rcfg, s_wcfg;
  supervisor_pkg::wd_mode_t    live;
  logic                        adj_q;
  supervisor_pkg::dly_t        rst_cap_q, wd_cap_q, rst_len_q, el_q, upper, lower;
  logic [1:0]                  rcfg_q, wcfg_q;
  supervisor_pkg::rst_state_t  st_q, st_d;
  supervisor_pkg::wd_mode_t    mode_q;
  logic                        fault, wd_en, en_q, kick_q, kick_fall, first_q;
  logic                        wd_run, viol, rst_oe_q, wdo_oe_q;
  logic                        apb_wr, apb_setup, addr_ok;

  timer_if pd ();
  timer_if settle ();
  timer_if flt ();

  // Time base
  always_ff @(posedge SYS_CLK) begin
    if (RST || pre_q == PRE_MAX) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end
  assign tick = (pre_q == PRE_MAX);

  pin_sync #(.W(10), .INIT(10'h200)) u_sync (
    .clk (SYS_CLK),
    .rst (RST),
    .d   ({WATCHDOG_KICK_IN, WINDOW_SELECT0, WINDOW_SELECT1, SENSE_UNDER, SENSE_OVER,
           SUPPLY_LOCKOUT, RESET_DELAY_CONFIG_PIN, WATCHDOG_TIMING_CONFIG_PIN}),
    .q   (sync_q)
  );
  assign s_kick  = sync_q[9];
  assign live    = supervisor_pkg::wd_mode_t'(sync_q[8:7]);
  assign s_under = sync_q[6];
  assign s_over  = sync_q[5];
  assign s_lock  = sync_q[4];
  assign s_rcfg  = sync_q[3:2];
  assign s_wcfg  = sync_q[1:0];

  interval_timer u_pd (.clk(SYS_CLK), .rst(RST), .tick(tick), .t(pd.tmr));
  interval_timer u_settle (.clk(SYS_CLK), .rst(RST), .tick(tick), .t(settle.tmr));
  interval_timer u_flt (.clk(SYS_CLK), .rst(RST), .tick(tick), .t(flt.tmr));

  // Supervisor sequencer
  assign fault = s_lock || s_under || (s_over && !adj_q);

  always_comb begin
    st_d = st_q;
    if (fault) begin
      st_d = supervisor_pkg::RS_HOLD;
    end else begin
      unique case (st_q)
        supervisor_pkg::RS_HOLD:  st_d = supervisor_pkg::RS_PROBE;
        supervisor_pkg::RS_PROBE: if (pd.done) st_d = supervisor_pkg::RS_DELAY;
        supervisor_pkg::RS_DELAY: if (pd.done) st_d = supervisor_pkg::RS_RUN;
        supervisor_pkg::RS_RUN:   st_d = supervisor_pkg::RS_RUN;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q     <= supervisor_pkg::RS_HOLD;
      rst_oe_q <= 1'b1;
    end else begin
      st_q     <= st_d;
      rst_oe_q <= (st_d != supervisor_pkg::RS_RUN);
    end
  end

  assign pd.start  = !fault && ((st_q == supervisor_pkg::RS_HOLD) ||
                     (st_q == supervisor_pkg::RS_PROBE && pd.done));
  assign pd.stop   = fault;
  assign pd.length = (st_q == supervisor_pkg::RS_HOLD) ? supervisor_pkg::PROBE_US :
                     supervisor_pkg::rst_len_of(s_rcfg, rst_cap_q);

  // Probe results
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rcfg_q    <= supervisor_pkg::PIN_OPEN;
      wcfg_q    <= supervisor_pkg::PIN_OPEN;
      rst_len_q <= supervisor_pkg::RST_NC_US;
    end else if (st_q == supervisor_pkg::RS_PROBE && pd.done && !fault) begin
      rcfg_q    <= s_rcfg;
      wcfg_q    <= s_wcfg;
      rst_len_q <= supervisor_pkg::rst_len_of(s_rcfg, rst_cap_q);
    end
  end

  // Select latching
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_q <= supervisor_pkg::WD_R1_8;
    end else if (st_q == supervisor_pkg::RS_HOLD) begin
      mode_q <= live;
    end else if (mode_q == supervisor_pkg::WD_OFF && live != supervisor_pkg::WD_OFF) begin
      mode_q <= live;
    end
  end

  assign wd_en = (live != supervisor_pkg::WD_OFF);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      en_q   <= 1'b0;
      kick_q <= 1'b1;
    end else begin
      en_q   <= wd_en;
      kick_q <= s_kick;
    end
  end

  assign settle.start  = wd_en && !en_q && st_q == supervisor_pkg::RS_RUN;
  assign settle.stop   = !wd_en || st_q != supervisor_pkg::RS_RUN;
  assign settle.length = supervisor_pkg::SETTLE_US;

  // Window watchdog
  assign kick_fall = kick_q && !s_kick;
  assign wd_run    = st_q == supervisor_pkg::RS_RUN && !fault && wd_en && !settle.busy &&
                     !settle.start && !flt.busy;
  assign upper     = supervisor_pkg::upper_of(wcfg_q, mode_q, wd_cap_q);
  assign lower     = supervisor_pkg::lower_of(upper, mode_q);
  assign viol      = wd_run && ((kick_fall && !first_q && el_q < lower) ||
                     (!kick_fall && el_q >= upper));

  always_ff @(posedge SYS_CLK) begin
    if (RST || !wd_run || viol) begin
      el_q    <= '0;
      first_q <= 1'b1;
    end else if (kick_fall) begin
      el_q    <= '0;
      first_q <= 1'b0;
    end else if (tick) begin
      el_q <= el_q + supervisor_pkg::dly_t'(1);
    end
  end

  assign flt.start  = viol;
  assign flt.stop   = !wd_en || st_q != supervisor_pkg::RS_RUN;
  assign flt.length = rst_len_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wdo_oe_q <= 1'b0;
    end else begin
      wdo_oe_q <= st_d == supervisor_pkg::RS_RUN && wd_en &&
                  (viol || (flt.busy && !flt.done && !flt.stop));
    end
  end

  assign RESET_N_O               = 1'b0;
  assign RESET_N_OE              = rst_oe_q;
  assign WATCHDOG_FAULT_OUT_N_O  = 1'b0;
  assign WATCHDOG_FAULT_OUT_N_OE = wdo_oe_q;
  assign PROBE_ACTIVE            = (st_q == supervisor_pkg::RS_PROBE);

  // APB slave
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign addr_ok   = PADDR == supervisor_pkg::REG_CTRL || PADDR == supervisor_pkg::REG_RST_CAP ||
                     PADDR == supervisor_pkg::REG_WD_CAP || PADDR == supervisor_pkg::REG_STATUS;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !addr_ok;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      adj_q     <= supervisor_pkg::CTRL_RST;
      rst_cap_q <= supervisor_pkg::RST_CAP_RST;
      wd_cap_q  <= supervisor_pkg::WD_CAP_RST;
    end else if (apb_wr) begin
      if (PADDR == supervisor_pkg::REG_CTRL) adj_q <= PWDATA[supervisor_pkg::CTRL_ADJ_BIT];
      if (PADDR == supervisor_pkg::REG_RST_CAP) begin
        rst_cap_q <= supervisor_pkg::clamp_cap(PWDATA[supervisor_pkg::DLY_W-1:0]);
      end
      if (PADDR == supervisor_pkg::REG_WD_CAP) wd_cap_q <= PWDATA[supervisor_pkg::DLY_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (apb_setup) begin
      PRDATA <= 32'h00000000;
      if (PADDR == supervisor_pkg::REG_CTRL) PRDATA[supervisor_pkg::CTRL_ADJ_BIT] <= adj_q;
      if (PADDR == supervisor_pkg::REG_RST_CAP) PRDATA[supervisor_pkg::DLY_W-1:0] <= rst_cap_q;
      if (PADDR == supervisor_pkg::REG_WD_CAP) PRDATA[supervisor_pkg::DLY_W-1:0] <= wd_cap_q;
      if (PADDR == supervisor_pkg::REG_STATUS) begin
        PRDATA[supervisor_pkg::ST_RESET_BIT] <= rst_oe_q;
        PRDATA[supervisor_pkg::ST_WDO_BIT]   <= wdo_oe_q;
        PRDATA[supervisor_pkg::ST_EN_BIT]    <= wd_en;
        PRDATA[supervisor_pkg::ST_FIRST_BIT] <= first_q;
        PRDATA[supervisor_pkg::ST_MODE_LSB+:2] <= mode_q;
        PRDATA[supervisor_pkg::ST_RCFG_LSB+:2] <= rcfg_q;
        PRDATA[supervisor_pkg::ST_WCFG_LSB+:2] <= wcfg_q;
      end
    end
  end

  // Ticks spent in the current sequencer state
  supervisor_pkg::dly_t ph_q;
  always_ff @(posedge SYS_CLK) begin
    if (RST || st_d != st_q) begin
      ph_q <= '0;
    end else if (tick) begin
      ph_q <= ph_q + supervisor_pkg::dly_t'(1);
    end
  end

  // Checks
  a_fault_asserts: assert property (@(posedge SYS_CLK) disable iff (RST)
    fault |=> RESET_N_OE && !WATCHDOG_FAULT_OUT_N_OE)
    else $error("reset not asserted on fault");

  a_window_keeps: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_RUN && !fault |=> !RESET_N_OE)
    else $error("reset asserted while in window");

  a_probe_length: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_PROBE && st_d == supervisor_pkg::RS_DELAY
    |-> ph_q == supervisor_pkg::PROBE_US)
    else $error("probe length wrong");

  a_hold_length: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_DELAY && st_d == supervisor_pkg::RS_RUN
    |-> ph_q == rst_len_q && RESET_N_OE)
    else $error("reset hold length wrong");

  a_release_od: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_DELAY && pd.done && !fault
    |=> !RESET_N_OE && RESET_N_O == 1'b0)
    else $error("reset not released after hold");

  a_reprobe: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_HOLD && !fault |=> PROBE_ACTIVE)
    else $error("no probe on window entry");

  a_adj_no_over: assert property (@(posedge SYS_CLK) disable iff (RST)
    adj_q && st_q == supervisor_pkg::RS_RUN && !s_under && !s_lock |=> !RESET_N_OE)
    else $error("over voltage acted in adjustable variant");

  a_off_quiet: assert property (@(posedge SYS_CLK) disable iff (RST)
    live == supervisor_pkg::WD_OFF |=> !WATCHDOG_FAULT_OUT_N_OE)
    else $error("fault output while disabled");

  a_settle_ignore: assert property (@(posedge SYS_CLK) disable iff (RST)
    settle.start |=> !wd_run [*8])
    else $error("watchdog ran during settling");

  a_timing_kept: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q != supervisor_pkg::RS_HOLD && mode_q != supervisor_pkg::WD_OFF
    |=> mode_q == $past(mode_q))
    else $error("timing changed without reset event");

  a_event_latch: assert property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_HOLD |=> mode_q == $past(live))
    else $error("select not latched on reset event");

  a_early_kick: assert property (@(posedge SYS_CLK) disable iff (RST)
    wd_run && kick_fall && !first_q && el_q < lower && !fault
    |=> WATCHDOG_FAULT_OUT_N_OE && first_q)
    else $error("early kick not flagged");

  a_first_free: assert property (@(posedge SYS_CLK) disable iff (RST)
    wd_run && kick_fall && first_q && el_q < upper |=> !flt.busy && !first_q)
    else $error("first kick wrongly flagged");

  a_reset_quiet: assert property (@(posedge SYS_CLK) disable iff (RST)
    RESET_N_OE |-> !WATCHDOG_FAULT_OUT_N_OE && el_q == '0)
    else $error("watchdog active during reset");

  c_to_run: cover property (@(posedge SYS_CLK) disable iff (RST)
    st_q == supervisor_pkg::RS_DELAY ##1 st_q == supervisor_pkg::RS_RUN);
  c_wdo_fault: cover property (@(posedge SYS_CLK) disable iff (RST)
    $rose(WATCHDOG_FAULT_OUT_N_OE));
  c_good_kick: cover property (@(posedge SYS_CLK) disable iff (RST)
    wd_run && kick_fall && !first_q && el_q >= lower);
  c_settle: cover property (@(posedge SYS_CLK) disable iff (RST) settle.start);

endmodule : supervisor_window_watchdog

// ===== test/kick_host_model.sv
/*
  Host model that issues one watchdog kick per request.
  Assumes the bench shares the system clock and reset.
*/
module kick_host_model #(
  parameter int CYC_PER_US = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request from bench
  input  wire logic        req,
  input  wire logic [15:0] gap_us,
  output logic             busy,
  // Kick pin
  output logic             kick
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // Driven line, idles high, falls once per request
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      kick <= 1'b1;
      cnt  <= 0;
    end else if (!busy) begin
      busy <= req;
      cnt  <= int'(gap_us) * CYC_PER_US + 8;
    end else if (cnt > 0) begin
      cnt  <= cnt - 1;
      kick <= cnt > 8;
    end else begin
      busy <= 1'b0;
      kick <= 1'b1;
    end
  end
endmodule : kick_host_model

// ===== test/supervisor_window_watchdog_tb_top.sv
/*
  Self-checking bench for the supervisor and window watchdog.
  Assumes capacitor probe codes and a shortened microsecond tick.
*/
module supervisor_window_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPU = 4;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        under, over, lockout, probe, sel0, sel1, kick, req, busy, err;
  logic [1:0]  rcfg, wcfg;
  logic [15:0] gap;
  logic        rst_o, rst_oe, wdo_o, wdo_oe;
  wire         reset_line = rst_oe ? rst_o : 1'b1;
  wire         fault_line = wdo_oe ? wdo_o : 1'b1;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n;

  supervisor_window_watchdog #(.CYC_PER_US(CPU)) dut_u (
    .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SENSE_UNDER(under), .SENSE_OVER(over), .SUPPLY_LOCKOUT(lockout),
    .RESET_DELAY_CONFIG_PIN(rcfg), .WATCHDOG_TIMING_CONFIG_PIN(wcfg), .PROBE_ACTIVE(probe),
    .WINDOW_SELECT0(sel0), .WINDOW_SELECT1(sel1), .WATCHDOG_KICK_IN(kick),
    .RESET_N_O(rst_o), .RESET_N_OE(rst_oe),
    .WATCHDOG_FAULT_OUT_N_O(wdo_o), .WATCHDOG_FAULT_OUT_N_OE(wdo_oe));

  kick_host_model #(.CYC_PER_US(CPU)) host_u (
    .clk(sys_clk), .rst(rst), .req(req), .gap_us(gap), .busy(busy), .kick(kick));

  task automatic check(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if (!(seen === lo || (seen >= lo && seen <= hi) === 1'b1)) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, lo);
    end
  endtask : check

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input logic e_err);
    apb(1'b0, a, 32'h0);
    check(rd, e, e);
    check(32'(err), 32'(e_err), 32'(e_err));
  endtask : reg_chk

  function automatic logic sig(input int s);
    return s == 0 ? reset_line : s == 1 ? fault_line : probe;
  endfunction : sig

  // Bounded wait; n holds the cycles spent
  task automatic wait_lvl(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n < lim), 32'h1, 32'h1);
  endtask : wait_lvl

  task automatic do_kick(input int us);
    gap <= 16'(us);
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (busy === 1'b1) @(posedge sys_clk);
  endtask : do_kick

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    under = 1'b0;
    over = 1'b0;
    lockout = 1'b0;
    rcfg = 2'h2;
    wcfg = 2'h2;
    sel0 = 1'b0;
    sel1 = 1'b0;
    req = 1'b0;
    gap = 16'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // Register defaults, clamping, unmapped place
    reg_chk(8'h00, 32'h0, 1'b0);
    reg_chk(8'h04, 32'h0000_02BF, 1'b0);
    reg_chk(8'h08, 32'h0000_2710, 1'b0);
    reg_chk(8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'h0);
    reg_chk(8'h04, 32'h0000_02BF, 1'b0);
    apb(1'b1, 8'h04, 32'h003F_FFFF);
    reg_chk(8'h04, 32'h0031_2220, 1'b0);
    apb(1'b1, 8'h04, 32'h0000_02BF);
    apb(1'b1, 8'h08, 32'h0000_0190);
    wait_lvl(0, 1'b1, 6000);
    // Under-voltage, reentry with a fresh probe
    under <= 1'b1;
    wait_lvl(0, 1'b0, 8);
    under <= 1'b0;
    wait_lvl(2, 1'b1, 12);
    wait_lvl(2, 1'b0, 1600);
    check(n, 1524, 1532);
    wait_lvl(0, 1'b1, 3000);
    check(n, 2812, 2822);
    // Over-voltage ignored only in adjustable variant
    apb(1'b1, 8'h00, 32'h1);
    over <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check(reset_line, 1'b1, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    wait_lvl(0, 1'b0, 8);
    over <= 1'b0;
    wait_lvl(0, 1'b1, 5000);
    // First kick upper only, then an early one
    do_kick(20);
    check(fault_line, 1'b1, 1'b1);
    do_kick(20);
    wait_lvl(1, 1'b0, 12);
    wait_lvl(1, 1'b1, 3000);
    check(n, 2804, 2812);
    // Legal window, then a missed kick
    do_kick(100);
    do_kick(200);
    do_kick(200);
    check(fault_line, 1'b1, 1'b1);
    wait_lvl(1, 1'b0, 1700);
    check(n, 1570, 1610);
    // Disable clears the fault at once
    sel0 <= 1'b1;
    wait_lvl(1, 1'b1, 6);
    repeat (2400) @(posedge sys_clk);
    check(fault_line, 1'b1, 1'b1);
    // Enable: kicks ignored while settling
    sel0 <= 1'b0;
    do_kick(10);
    do_kick(10);
    do_kick(10);
    check(fault_line, 1'b1, 1'b1);
    do_kick(150);
    do_kick(10);
    wait_lvl(1, 1'b0, 12);
    wait_lvl(1, 1'b1, 3000);
    // Ratio change waits for a reset event
    sel1 <= 1'b1;
    do_kick(100);
    do_kick(100);
    check(fault_line, 1'b1, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd & 32'h30, 32'h0, 32'h0);
    lockout <= 1'b1;
    wait_lvl(0, 1'b0, 8);
    check(fault_line, 1'b1, 1'b1);
    lockout <= 1'b0;
    wait_lvl(0, 1'b1, 5000);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd & 32'h30, 32'h10, 32'h10);
    do_kick(100);
    do_kick(100);
    wait_lvl(1, 1'b0, 12);
    // Ratio 1:2 latched by the next reset event
    sel0    <= 1'b1;
    lockout <= 1'b1;
    wait_lvl(0, 1'b0, 8);
    lockout <= 1'b0;
    wait_lvl(0, 1'b1, 5000);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd & 32'h30, 32'h30, 32'h30);
    check(rd & 32'h3C0, 32'h280, 32'h280);
    do_kick(250);
    do_kick(250);
    check(fault_line, 1'b1, 1'b1);
    do_kick(100);
    wait_lvl(1, 1'b0, 12);
    print_verdict();
  end
endmodule : supervisor_window_watchdog_tb_top
